// file: src/sslenc_pkg.sv
// Constants, register map and types of the safety status indicator encoder
package sslenc_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ            = 25000000;
   localparam int unsigned BLINK_HALF_MS     = 250;
   localparam int unsigned BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;
   localparam int unsigned ILOCK_QUIET_S     = 1;
   localparam int unsigned ILOCK_CYCLES      = ILOCK_QUIET_S * CLK_HZ;
   localparam int unsigned SEL_SETTLE_CYCLES = 4;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned NUM_IN    = 3;
   localparam int unsigned SEL_W     = 16;
   localparam int unsigned ADDR_W    = 4;
   localparam int unsigned DATA_W    = 32;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL     = 4'h0;
   localparam logic [3:0] ADDR_STATUS   = 4'h4;
   localparam logic [3:0] ADDR_SELECTOR = 4'h8;

   // Control fields
   localparam int unsigned CTRL_LAMP_TEST_BIT = 0;
   localparam logic        CTRL_LAMP_TEST_RST = 1'b0;

   // Status fields
   localparam int unsigned ST_ERR_LSB    = 0;
   localparam int unsigned ST_SYNC_BIT   = 4;
   localparam int unsigned ST_ILOCK_BIT  = 5;
   localparam int unsigned ST_SAFE_BIT   = 6;
   localparam int unsigned ST_SUPPLY_BIT = 7;
   localparam int unsigned ST_MASK_LSB   = 8;

   // ----------------------------------------------------------------
   // Latched error codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SSLENC_ERR_NONE    = 4'h0,
      SSLENC_ERR_CONFIG  = 4'h1,
      SSLENC_ERR_GENERAL = 4'h2,
      SSLENC_ERR_SUPPLY  = 4'h3,
      SSLENC_ERR_EXT_OUT = 4'h4,
      SSLENC_ERR_INST    = 4'h5,
      SSLENC_ERR_DLY     = 4'h6,
      SSLENC_ERR_START   = 4'h7,
      SSLENC_ERR_IN_XC   = 4'h8
   } sslenc_err_t;

   // Start condition codes
   localparam logic [1:0] START_NOT_MET = 2'h0;
   localparam logic [1:0] START_MET     = 2'h1;
   localparam logic [1:0] START_WAITING = 2'h2;

endpackage

// file: src/sslenc_blink_if.sv
// Shared blink timebase carrier between divider and encoder
`timescale 1ns/1ps
`default_nettype none
interface sslenc_blink_if;
   logic phase;
   modport src (output phase);
   modport dst (input  phase);
endinterface
`default_nettype wire

// file: src/sslenc_blink.sv
// Blink timebase divider producing one shared flash phase
`timescale 1ns/1ps
`default_nettype none
module sslenc_blink #(
   parameter int unsigned HALF_CYCLES = sslenc_pkg::BLINK_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   // Timebase out
   sslenc_blink_if.src    blink
);

   logic [31:0] cnt_reg;
   logic        phase_reg;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------

   // Count one half period, then flip the phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg   <= 32'h0;
         phase_reg <= 1'b0;
      end else if (cnt_reg == 32'(HALF_CYCLES - 1)) begin
         cnt_reg   <= 32'h0;
         phase_reg <= ~phase_reg;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
      end
   end

   assign blink.phase = phase_reg;

endmodule
`default_nettype wire

// file: src/sslenc_selmon.sv
// Selector monitor: power-up capture and change detection
`timescale 1ns/1ps
`default_nettype none
module sslenc_selmon (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Selector pins
   input  wire logic [sslenc_pkg::SEL_W-1:0] sel_i,
   // Results
   output logic      [sslenc_pkg::SEL_W-1:0] sel_cap_o,
   output logic                              changed_o
);

   logic [sslenc_pkg::SEL_W-1:0] sync1_reg;
   logic [sslenc_pkg::SEL_W-1:0] sync2_reg;
   logic [sslenc_pkg::SEL_W-1:0] cap_reg;
   logic [2:0]                   settle_reg;
   logic                         armed_reg;
   logic                         changed_reg;

   // ----------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------

   // Two stages before anything looks at the pins
   always_ff @(posedge clk_i) begin
      sync1_reg <= sel_i;
      sync2_reg <= sync1_reg;
   end

   // ----------------------------------------------------------------
   // Capture and compare
   // ----------------------------------------------------------------

   // Wait for the synchroniser to fill, then capture once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_reg <= 3'h0;
         armed_reg  <= 1'b0;
         cap_reg    <= '0;
      end else if (!armed_reg) begin
         if (settle_reg == 3'(sslenc_pkg::SEL_SETTLE_CYCLES - 1)) begin
            armed_reg <= 1'b1;
            cap_reg   <= sync2_reg;
         end else begin
            settle_reg <= settle_reg + 3'h1;
         end
      end
   end

   // Any later difference is a change under power
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         changed_reg <= 1'b0;
      end else begin
         changed_reg <= armed_reg && (sync2_reg != cap_reg);
      end
   end

   assign sel_cap_o = cap_reg;
   assign changed_o = changed_reg;

endmodule
`default_nettype wire

// file: src/sslenc_top.sv
// Front-panel status indicator encoder of a safety relay module
//
// What this block does
// - First output indicator lit while instantaneous outputs active, dark otherwise.
// - Second output indicator lit while delayed outputs active, dark otherwise.
// - Start indicator dark not met, lit met, flashing while waiting.
// - Each input indicator follows its safety input terminal.
// - Alerts flash error indicator with affected input indicators.
// - Alerts force safe state; normal operation resumes once cause clears.
// - Synchronisation timeout: error flashes, paired input indicators flash in antiphase.
// - Interlock: flash error and both inputs in phase; release after quiet second.
// - Detected error latches safe state, error lit; only reset clears it.
// - General error: outputs, start and inputs flash together, error lit.
// - Supply fault: error lit, supply indicator flashes.
// - Instantaneous output fault: error lit, first output indicator flashes.
// - Delayed output fault: error lit, second output indicator flashes.
// - Start cross circuit: error lit, start indicator flashes.
// - Input pair cross circuit: error lit, two affected inputs flash together.
// - Supply indicator lit while powered, dark without supply.
// - Selector change under power raises configuration error; selectors sampled at power-up.
`timescale 1ns/1ps
`default_nettype none
module sslenc_top #(
   parameter int unsigned BLINK_HALF_CYCLES = sslenc_pkg::BLINK_HALF_CYCLES,
   parameter int unsigned ILOCK_CYCLES      = sslenc_pkg::ILOCK_CYCLES
) (
   // Clock and reset
   input  wire logic                          MCLK_I,
   input  wire logic                          SYS_RST_I,
   // Register port
   input  wire logic [sslenc_pkg::ADDR_W-1:0] REG_ADDR_I,
   input  wire logic [sslenc_pkg::DATA_W-1:0] REG_WDATA_I,
   input  wire logic                          REG_WR_I,
   input  wire logic                          REG_RD_I,
   output logic      [sslenc_pkg::DATA_W-1:0] REG_RDATA_O,
   // Pins from outside the clock domain
   input  wire logic                          SUPPLY_OK_I,
   input  wire logic [sslenc_pkg::SEL_W-1:0]  SELECTOR_I,
   // Safety state machine status
   input  wire logic                          INST_ACTIVE_I,
   input  wire logic                          DLY_ACTIVE_I,
   input  wire logic [1:0]                    START_STATE_I,
   input  wire logic [sslenc_pkg::NUM_IN-1:0] SAFETY_IN_I,
   // Alerts from safety state machine
   input  wire logic                          ALERT_SYNC_I,
   input  wire logic                          ALERT_ILOCK_I,
   input  wire logic [sslenc_pkg::NUM_IN-1:0] ALERT_MASK_I,
   // Detected error events
   input  wire logic                          ERR_GENERAL_I,
   input  wire logic                          ERR_SUPPLY_I,
   input  wire logic                          ERR_EXT_OUT_I,
   input  wire logic                          ERR_INST_OUT_I,
   input  wire logic                          ERR_DLY_OUT_I,
   input  wire logic                          ERR_START_XC_I,
   input  wire logic                          ERR_IN_XC_I,
   input  wire logic [sslenc_pkg::NUM_IN-1:0] ERR_IN_MASK_I,
   // Safe state request
   output logic                               SAFE_STATE_O,
   // Indicators
   output logic                               POWER_INDICATOR_O,
   output logic                               INSTANT_OUTPUT_INDICATOR_O,
   output logic                               DELAYED_OUTPUT_INDICATOR_O,
   output logic                               START_INDICATOR_O,
   output logic                               ERROR_INDICATOR_O,
   output logic      [sslenc_pkg::NUM_IN-1:0] INPUT_INDICATOR_O
);

   localparam int unsigned N = sslenc_pkg::NUM_IN;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Whether bit k is the lowest set bit of a mask
   function automatic logic lowest_bit(input logic [N-1:0] m, input int k);
      lowest_bit = |((m & (~m + N'(1))) & (N'(1) << k));
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   sslenc_blink_if blink_bus ();

   logic                         supply_s1_reg;
   logic                         supply_s2_reg;
   logic [sslenc_pkg::SEL_W-1:0] sel_cap;
   logic                         sel_changed;

   sslenc_pkg::sslenc_err_t      err_reg;
   sslenc_pkg::sslenc_err_t      err_next;
   logic [N-1:0]                 err_mask_reg;

   logic                         ilock_hold_reg;
   logic [N-1:0]                 ilock_mask_reg;
   logic [31:0]                  quiet_cnt_reg;
   logic                         quiet;

   logic                         lamp_test_reg;
   logic [sslenc_pkg::DATA_W-1:0] rdata_reg;
   logic [sslenc_pkg::DATA_W-1:0] status_word;

   logic                         led_pwr_next;
   logic                         led_inst_next;
   logic                         led_dly_next;
   logic                         led_start_next;
   logic                         led_err_next;
   logic [N-1:0]                 led_in_next;
   logic                         ph;
   logic                         alert_any;
   logic                         safe_next;

   logic                         led_pwr_reg;
   logic                         led_inst_reg;
   logic                         led_dly_reg;
   logic                         led_start_reg;
   logic                         led_err_reg;
   logic [N-1:0]                 led_in_reg;
   logic                         safe_reg;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------

   // Shared flash phase for every indicator
   sslenc_blink #(
      .HALF_CYCLES (BLINK_HALF_CYCLES)
   ) u_blink (
      .clk_i       (MCLK_I),
      .rst_i       (SYS_RST_I),
      .blink       (blink_bus.src)
   );

   // Selector capture and change detection
   sslenc_selmon u_selmon (
      .clk_i       (MCLK_I),
      .rst_i       (SYS_RST_I),
      .sel_i       (SELECTOR_I),
      .sel_cap_o   (sel_cap),
      .changed_o   (sel_changed)
   );

   assign ph = blink_bus.phase;

   // ----------------------------------------------------------------
   // Supply pin synchroniser
   // ----------------------------------------------------------------

   // Two stages on the supply sense pin
   always_ff @(posedge MCLK_I) begin
      supply_s1_reg <= SUPPLY_OK_I;
      supply_s2_reg <= supply_s1_reg;
   end

   // ----------------------------------------------------------------
   // Detected error latch
   // ----------------------------------------------------------------

   // Pick the most severe error raised this cycle
   always_comb begin
      err_next = sslenc_pkg::SSLENC_ERR_NONE;
      if (sel_changed) begin
         err_next = sslenc_pkg::SSLENC_ERR_CONFIG;
      end else if (ERR_GENERAL_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_GENERAL;
      end else if (ERR_SUPPLY_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_SUPPLY;
      end else if (ERR_EXT_OUT_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_EXT_OUT;
      end else if (ERR_INST_OUT_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_INST;
      end else if (ERR_DLY_OUT_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_DLY;
      end else if (ERR_START_XC_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_START;
      end else if (ERR_IN_XC_I) begin
         err_next = sslenc_pkg::SSLENC_ERR_IN_XC;
      end
   end

   // First error sticks until the next reset
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         err_reg      <= sslenc_pkg::SSLENC_ERR_NONE;
         err_mask_reg <= '0;
      end else if (err_reg == sslenc_pkg::SSLENC_ERR_NONE &&
                   err_next != sslenc_pkg::SSLENC_ERR_NONE) begin
         err_reg      <= err_next;
         err_mask_reg <= ERR_IN_MASK_I;
      end
   end

   // ----------------------------------------------------------------
   // Interlock hold
   // ----------------------------------------------------------------

   // Affected inputs quiet and no new interlock alert
   assign quiet = !ALERT_ILOCK_I && ((SAFETY_IN_I & ilock_mask_reg) == '0);

   // Hold until affected inputs stay inactive for the full quiet time
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ilock_hold_reg <= 1'b0;
         ilock_mask_reg <= '0;
         quiet_cnt_reg  <= 32'h0;
      end else if (ALERT_ILOCK_I) begin
         ilock_hold_reg <= 1'b1;
         ilock_mask_reg <= ALERT_MASK_I;
         quiet_cnt_reg  <= 32'h0;
      end else if (ilock_hold_reg) begin
         if (!quiet) begin
            quiet_cnt_reg <= 32'h0;
         end else if (quiet_cnt_reg == 32'(ILOCK_CYCLES - 1)) begin
            ilock_hold_reg <= 1'b0;
            quiet_cnt_reg  <= 32'h0;
         end else begin
            quiet_cnt_reg <= quiet_cnt_reg + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Safe state
   // ----------------------------------------------------------------

   // Alerts release on their own; latched errors do not
   assign alert_any = ALERT_SYNC_I || ALERT_ILOCK_I || ilock_hold_reg;
   assign safe_next = alert_any || (err_reg != sslenc_pkg::SSLENC_ERR_NONE);

   // ----------------------------------------------------------------
   // Indicator encoding
   // ----------------------------------------------------------------

   // Normal view, then alert patterns, then error patterns on top
   always_comb begin
      led_pwr_next   = supply_s2_reg;
      led_inst_next  = INST_ACTIVE_I;
      led_dly_next   = DLY_ACTIVE_I;
      led_in_next    = SAFETY_IN_I;
      led_err_next   = 1'b0;
      case (START_STATE_I)
         sslenc_pkg::START_MET:     led_start_next = 1'b1;
         sslenc_pkg::START_WAITING: led_start_next = ph;
         default:                   led_start_next = 1'b0;
      endcase
      if (ALERT_SYNC_I) begin
         led_err_next = ph;
         for (int i = 0; i < N; i++) begin
            if (ALERT_MASK_I[i]) begin
               led_in_next[i] = lowest_bit(ALERT_MASK_I, i) ? ph : ~ph;
            end
         end
      end else if (ALERT_ILOCK_I || ilock_hold_reg) begin
         led_err_next = ph;
         for (int i = 0; i < N; i++) begin
            if (ilock_mask_reg[i] || (ALERT_ILOCK_I && ALERT_MASK_I[i])) begin
               led_in_next[i] = ph;
            end
         end
      end
      if (err_reg != sslenc_pkg::SSLENC_ERR_NONE) begin
         led_err_next = 1'b1;
         case (err_reg)
            sslenc_pkg::SSLENC_ERR_GENERAL: begin
               led_inst_next  = ph;
               led_dly_next   = ph;
               led_start_next = ph;
               led_in_next    = {N{ph}};
            end
            sslenc_pkg::SSLENC_ERR_CONFIG: begin
               led_inst_next  = 1'b1;
               led_dly_next   = 1'b1;
               led_start_next = 1'b1;
               led_in_next    = {N{1'b1}};
            end
            sslenc_pkg::SSLENC_ERR_SUPPLY: begin
               led_pwr_next = supply_s2_reg & ph;
            end
            sslenc_pkg::SSLENC_ERR_INST: begin
               led_inst_next = ph;
            end
            sslenc_pkg::SSLENC_ERR_DLY: begin
               led_dly_next = ph;
            end
            sslenc_pkg::SSLENC_ERR_START: begin
               led_start_next = ph;
            end
            sslenc_pkg::SSLENC_ERR_EXT_OUT: begin
               led_inst_next  = ph;
               led_dly_next   = ph;
               led_start_next = ph;
            end
            sslenc_pkg::SSLENC_ERR_IN_XC: begin
               for (int i = 0; i < N; i++) begin
                  if (err_mask_reg[i]) begin
                     led_in_next[i] = ph;
                  end
               end
            end
            default: begin
               led_err_next = 1'b1;
            end
         endcase
      end
      if (lamp_test_reg) begin
         led_pwr_next   = supply_s2_reg;
         led_inst_next  = 1'b1;
         led_dly_next   = 1'b1;
         led_start_next = 1'b1;
         led_err_next   = 1'b1;
         led_in_next    = {N{1'b1}};
      end
   end

   // Register every indicator and the safe state request
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         led_pwr_reg   <= 1'b0;
         led_inst_reg  <= 1'b0;
         led_dly_reg   <= 1'b0;
         led_start_reg <= 1'b0;
         led_err_reg   <= 1'b0;
         led_in_reg    <= '0;
         safe_reg      <= 1'b1;
      end else begin
         led_pwr_reg   <= led_pwr_next;
         led_inst_reg  <= led_inst_next;
         led_dly_reg   <= led_dly_next;
         led_start_reg <= led_start_next;
         led_err_reg   <= led_err_next;
         led_in_reg    <= led_in_next;
         safe_reg      <= safe_next;
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------

   // Control register write
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         lamp_test_reg <= sslenc_pkg::CTRL_LAMP_TEST_RST;
      end else if (REG_WR_I && REG_ADDR_I == sslenc_pkg::ADDR_CTRL) begin
         lamp_test_reg <= REG_WDATA_I[sslenc_pkg::CTRL_LAMP_TEST_BIT];
      end
   end

   // Status word layout
   always_comb begin
      status_word = '0;
      status_word[sslenc_pkg::ST_ERR_LSB +: 4]  = err_reg;
      status_word[sslenc_pkg::ST_SYNC_BIT]      = ALERT_SYNC_I;
      status_word[sslenc_pkg::ST_ILOCK_BIT]     = ilock_hold_reg;
      status_word[sslenc_pkg::ST_SAFE_BIT]      = safe_reg;
      status_word[sslenc_pkg::ST_SUPPLY_BIT]    = supply_s2_reg;
      status_word[sslenc_pkg::ST_MASK_LSB +: N] = ilock_hold_reg ? ilock_mask_reg : err_mask_reg;
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !REG_RD_I) begin
         rdata_reg <= '0;
      end else begin
         case (REG_ADDR_I)
            sslenc_pkg::ADDR_CTRL:     rdata_reg <= 32'(lamp_test_reg);
            sslenc_pkg::ADDR_STATUS:   rdata_reg <= status_word;
            sslenc_pkg::ADDR_SELECTOR: rdata_reg <= 32'(sel_cap);
            default:                   rdata_reg <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_RDATA_O                = rdata_reg;
   assign SAFE_STATE_O               = safe_reg;
   assign POWER_INDICATOR_O          = led_pwr_reg;
   assign INSTANT_OUTPUT_INDICATOR_O = led_inst_reg;
   assign DELAYED_OUTPUT_INDICATOR_O = led_dly_reg;
   assign START_INDICATOR_O          = led_start_reg;
   assign ERROR_INDICATOR_O          = led_err_reg;
   assign INPUT_INDICATOR_O          = led_in_reg;

endmodule
`default_nettype wire

// file: bench/sslenc_monitor.sv
// Port-level checker of the status indicator encoder
`timescale 1ns/1ps
`default_nettype none
module sslenc_monitor #(
   parameter int unsigned BLINK_HALF_CYCLES = sslenc_pkg::BLINK_HALF_CYCLES,
   parameter int unsigned ILOCK_CYCLES      = sslenc_pkg::ILOCK_CYCLES
) (
   input wire logic       MCLK_I, SYS_RST_I, INST_ACTIVE_I, DLY_ACTIVE_I, ALERT_SYNC_I, ALERT_ILOCK_I,
   input wire logic       ERR_INST_OUT_I, SAFE_STATE_O, INSTANT_OUTPUT_INDICATOR_O,
   input wire logic       DELAYED_OUTPUT_INDICATOR_O, START_INDICATOR_O, ERROR_INDICATOR_O,
   input wire logic [1:0] START_STATE_I,
   input wire logic [2:0] SAFETY_IN_I, ALERT_MASK_I, INPUT_INDICATOR_O
);
   logic nrm;
   // Normal view: no error shown, outputs not held safe
   assign nrm = !ERROR_INDICATOR_O && !SAFE_STATE_O;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_hit; ERR_INST_OUT_I && !ERROR_INDICATOR_O ##1 1'b1; endsequence
   property p_inst; nrm |-> INSTANT_OUTPUT_INDICATOR_O == $past(INST_ACTIVE_I); endproperty
   property p_dly; nrm |-> DELAYED_OUTPUT_INDICATOR_O == $past(DLY_ACTIVE_I); endproperty
   property p_start;
      nrm && $past(START_STATE_I) != 2'h2 |-> START_INDICATOR_O == ($past(START_STATE_I) == 2'h1);
   endproperty
   property p_in; nrm |-> INPUT_INDICATOR_O == $past(SAFETY_IN_I); endproperty
   property p_err; s_hit |=> (ERROR_INDICATOR_O && SAFE_STATE_O) [*8]; endproperty
   property p_sync;
      ALERT_SYNC_I && ALERT_MASK_I == 3'h3 |=> SAFE_STATE_O && INPUT_INDICATOR_O[0] != INPUT_INDICATOR_O[1];
   endproperty
   property p_ilock;
      ALERT_ILOCK_I && ALERT_MASK_I == 3'h3 |=> SAFE_STATE_O && INPUT_INDICATOR_O[1:0] == {2{ERROR_INDICATOR_O}};
   endproperty
   property p_hold; $fell(ALERT_ILOCK_I) && SAFETY_IN_I == 3'h0 |-> SAFE_STATE_O [*8]; endproperty
   a_inst: assert property (p_inst) else $error("instant indicator wrong");
   a_dly: assert property (p_dly) else $error("delayed indicator wrong");
   a_start: assert property (p_start) else $error("start indicator wrong");
   a_in: assert property (p_in) else $error("input indicator wrong");
   a_err: assert property (p_err) else $error("error not latched");
   a_sync: assert property (p_sync) else $error("sync pattern wrong");
   a_ilock: assert property (p_ilock) else $error("interlock pattern wrong");
   a_hold: assert property (p_hold) else $error("interlock released early");
endmodule
bind sslenc_top sslenc_monitor #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES), .ILOCK_CYCLES(ILOCK_CYCLES)) mon (.*);
`default_nettype wire

// file: bench/sslenc_leds.sv
// Operator view of the panel: lit and dark sightings per indicator
`timescale 1ns/1ps
`default_nettype none
module sslenc_leds (
   input  wire logic       clk_i,
   input  wire logic       clr_i,
   input  wire logic [7:0] led_i,
   output logic      [7:0] on_o,
   output logic      [7:0] off_o
);
   // Both sightings in one window mean flashing
   always_ff @(posedge clk_i) begin
      on_o  <= clr_i ? 8'h00 : on_o | led_i;
      off_o <= clr_i ? 8'h00 : off_o | ~led_i;
   end
endmodule
`default_nettype wire

// file: bench/sslenc_top_test.sv
// Self-checking bench of the status indicator encoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module sslenc_top_test;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0, sup = 1'b1;
   logic        inst = 1'b0, dly = 1'b0, asy = 1'b0, ail = 1'b0, safe, pw, ii, di, si, ei;
   logic [1:0]  st = 2'h0;
   logic [2:0]  sin = 3'h0, am = 3'h0, ini;
   logic [3:0]  ad = 4'h0;
   logic [6:0]  ev = 7'h00;
   logic [7:0]  son, soff;
   logic [15:0] sel = 16'h3c5a;
   logic [31:0] wd = 32'h0, rdat, q;
   int          error_cnt = 0, tests_run = 0, n;
   // Rows: {inst, dly, start, inputs} then expected indicators
   logic [12:0] rows [4] = '{13'b1001101_101101, 13'b0100010_010010, 13'b1111111_110111, 13'b0001000_001000};
   // Flash masks per error event {power, inst, dly, start, error, inputs}
   logic [7:0]  errs [7] = '{8'h77, 8'h80, 8'h70, 8'h40, 8'h20, 8'h10, 8'h03};
   sslenc_top #(.BLINK_HALF_CYCLES(4), .ILOCK_CYCLES(20)) uut (
      .MCLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdat), .SUPPLY_OK_I(sup), .SELECTOR_I(sel), .INST_ACTIVE_I(inst), .DLY_ACTIVE_I(dly),
      .START_STATE_I(st), .SAFETY_IN_I(sin), .ALERT_SYNC_I(asy), .ALERT_ILOCK_I(ail), .ALERT_MASK_I(am),
      .ERR_GENERAL_I(ev[6]), .ERR_SUPPLY_I(ev[5]), .ERR_EXT_OUT_I(ev[4]), .ERR_INST_OUT_I(ev[3]),
      .ERR_DLY_OUT_I(ev[2]), .ERR_START_XC_I(ev[1]), .ERR_IN_XC_I(ev[0]), .ERR_IN_MASK_I(3'h3),
      .SAFE_STATE_O(safe), .POWER_INDICATOR_O(pw), .INSTANT_OUTPUT_INDICATOR_O(ii),
      .DELAYED_OUTPUT_INDICATOR_O(di), .START_INDICATOR_O(si), .ERROR_INDICATOR_O(ei), .INPUT_INDICATOR_O(ini));
   sslenc_leds leds (.clk_i(clk), .clr_i(clr), .led_i({pw, ii, di, si, ei, ini}), .on_o(son), .off_o(soff));
   initial forever #20 clk = ~clk;
   task automatic tick(int k); repeat (k) @(posedge clk); #1; endtask
   task automatic wr_reg(logic [3:0] a, logic [31:0] d);
      @(posedge clk) {wr, ad, wd} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [3:0] a);
      @(posedge clk) {rd, ad} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      #1 q = rdat;
   endtask
   // Clear the sighting record, then watch four blink half periods
   task automatic look();
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      tick(16);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      tick(5);
      `CHK({safe, pw, ei}, 3'h4)
      @(posedge clk) rst <= 1'b0;
      tick(8);
      `CHK(pw, 1'b1)
      wr_reg(4'h0, 32'h1);
      tick(1);
      `CHK({pw, ii, di, si, ei, ini}, 8'hff)
      wr_reg(4'h0, 32'h0);
      wr_reg(4'h8, 32'hffff);
      rd_reg(4'h8);
      `CHK(q, {16'h0, sel})
      rd_reg(4'hc);
      `CHK(q, 32'h0)
      foreach (rows[i]) begin
         @(posedge clk) {inst, dly, st, sin} <= rows[i][12:6];
         tick(2);
         `CHK({ii, di, si, ini}, rows[i][5:0])
      end
      @(posedge clk) st <= 2'h2;
      look();
      `CHK({son[4], soff[4]}, 2'h3)
      @(posedge clk) {asy, am, sin, st} <= {1'b1, 3'h3, 3'h3, 2'h0};
      look();
      `CHK({safe, son[3], soff[3], son[1:0], soff[1:0]}, 7'h7f)
      @(posedge clk) {asy, sin} <= 4'h0;
      tick(2);
      `CHK(safe, 1'b0)
      @(posedge clk) ail <= 1'b1;
      @(posedge clk) ail <= 1'b0;
      n = 0;
      do begin tick(1); n++; end while (safe !== 1'b0 && n < 100);
      `CHK(n > 19 && n < 26, 1'b1)
      if (n == 100) conclude();
      foreach (errs[i]) begin
         @(posedge clk) rst <= 1'b1;
         @(posedge clk) {rst, ev} <= {1'b0, 7'h40 >> i};
         @(posedge clk) ev <= 7'h00;
         tick(4);
         look();
         `CHK(safe, 1'b1)
         `CHK({son, soff}, {errs[i] | 8'h88, errs[i] | 8'h77})
         rd_reg(4'h4);
         `CHK(q[3:0], 4'(i + 2))
      end
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      tick(12);
      @(posedge clk) sel <= ~sel;
      tick(10);
      look();
      `CHK({son, soff}, 16'hff00)
      @(posedge clk) sup <= 1'b0;
      tick(4);
      `CHK(pw, 1'b0)
      conclude();
   end
   initial begin
      #400000;
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
